// ==== design/io_wake_defines.vh ====
// Register map, field positions and timing counts of the I/O wake block
`ifndef IO_WAKE_DEFINES_VH
`define IO_WAKE_DEFINES_VH

`define ADDR_PIN_DIR 6'h30
`define ADDR_PIN_OUT 6'h31
`define ADDR_PIN_IN 6'h32
`define ADDR_SYS_CFG 6'h33
`define ADDR_BTN_DET 6'h34
`define ADDR_BAT_CFG 6'h35

`define RST_BYTE 8'h00
`define RST_SIX 6'h00
`define RST_TWO 2'h0

`define DIR_HYST_BIT 6
`define CFG_SEL_HI 6
`define CFG_SEL_LO 5
`define CFG_TEST_BIT 4
`define CFG_DEAD_BIT 3
`define CFG_BLI_BIT 2
`define CFG_SLEEP_BIT 1
`define CFG_BOOT_BIT 0
`define BAT_RESULT_BIT 7
`define BAT_VALID_BIT 6

`define SEL_DIV16 2'h3
`define SEL_DIV32 2'h2
`define SEL_DIV64 2'h1
`define SEL_DIV128 2'h0
`define DIV16_LAST 7'h0F
`define DIV32_LAST 7'h1F
`define DIV64_LAST 7'h3F
`define DIV128_LAST 7'h7F

`define BAT_SAMPLE_XTAL 3100
`define XTAL_PER_SYS 1
`define BAT_SAMPLE_CYCLES (`BAT_SAMPLE_XTAL * `XTAL_PER_SYS)
`define WAKE_SETTLE_CYCLES 8'h40

`define SER_HDR_BITS 5'h08
`define SER_FRAME_BITS 5'h10
`define SER_WRITE_BIT 7

`endif

// ==== design/cpu_clock_divider.v ====
// Processor clock divider with boundary-aligned divide select
`timescale 1ns/1ps
`include "io_wake_defines.vh"
module cpu_clock_divider
(
  input wire clk_sys,
  input wire rstn,
  input wire run,
  input wire [1:0] sel,
  output reg cpu_clk,
  output reg cpu_tick
);
  reg [6:0] cnt_q;
  reg [6:0] last_q;
  reg [6:0] last_new;

  always @*
  begin
    case (sel)
      `SEL_DIV16: last_new = `DIV16_LAST;
      `SEL_DIV32: last_new = `DIV32_LAST;
      `SEL_DIV64: last_new = `DIV64_LAST;
      default: last_new = `DIV128_LAST;
    endcase
  end

  // New ratio only loads at wrap, so no period is ever cut short
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 7'h00;
      last_q <= `DIV128_LAST;
      cpu_clk <= 1'b0;
      cpu_tick <= 1'b0;
    end
    else if (run)
    begin
      cpu_tick <= (cnt_q == last_q);
      if (cnt_q == last_q)
      begin
        cnt_q <= 7'h00;
        last_q <= last_new;
      end
      else
      begin
        cnt_q <= cnt_q + 7'h01;
      end
      cpu_clk <= (cnt_q == last_q) || (cnt_q < {1'b0, last_q[6:1]});
    end
    else
    begin
      cpu_tick <= 1'b0;
      cpu_clk <= 1'b0;
    end
  end
endmodule

// ==== design/battery_sampler.v ====
// Battery-low sample sequencer with valid flag
`timescale 1ns/1ps
`include "io_wake_defines.vh"
module battery_sampler
(
  input wire clk_sys,
  input wire rstn,
  input wire restart,
  input wire below_level_raw,
  output reg low_result,
  output reg low_valid
);
  reg [11:0] cnt_q;
  reg busy_q;
  reg below_s1;
  reg below_s2;

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      below_s1 <= 1'b0;
      below_s2 <= 1'b0;
      cnt_q <= 12'h000;
      busy_q <= 1'b0;
      low_result <= 1'b0;
      low_valid <= 1'b0;
    end
    else
    begin
      below_s1 <= below_level_raw;
      below_s2 <= below_s1;
      if (restart)
      begin
        busy_q <= 1'b1;
        cnt_q <= 12'h000;
        low_valid <= 1'b0;
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q + 12'h001;
        // Comparator settles while counting; result taken at the end
        if (cnt_q == `BAT_SAMPLE_CYCLES - 1)
        begin
          busy_q <= 1'b0;
          low_result <= below_s2;
          low_valid <= 1'b1;
        end
      end
    end
  end
endmodule

// ==== design/io_wake_battery_control.v ====
// Six-pin I/O, sleep and wake, clock select and battery monitor control
// Behaviour
// - Enabled output pins drive output data bits
// - Upper two bits of three registers read zero
// - Input register reads live pins, writes ignored
// - Clock select divides crystal by 16..128
// - Select writable live; programming runs divide 16
// - Test mode routes transmitter and serial signals
// - Serial port pins ignore direction register
// - Serial host reads and writes I/O registers
// - Battery dead readable only over serial port
// - Low indicator mirrors battery monitor result bit
// - Sleep stops oscillator, processor and watchdog
// - Button wakes, checks battery, resumes or resleeps
// - Boot bit reboots on wake, then clears
// - Low button pin sets detect bit, good battery
// - Detect bit clears only by writing zero
// - Result valid only while valid bit set
// - Write clears valid; set within 3100 cycles
// - Level code forwarded to comparator unrestricted
// - Direction and data bits select pin mode
`timescale 1ns/1ps
`include "io_wake_defines.vh"
module io_wake_battery_control
(
  input wire clk_sys,
  input wire rstn,
  input wire [5:0] cpu_io_addr,
  input wire [7:0] cpu_io_wdata,
  input wire cpu_io_wr,
  input wire cpu_io_rd,
  output reg [7:0] cpu_io_rdata,
  input wire [5:0] pin_i,
  output reg [5:0] pin_o,
  output reg [5:0] pin_oe_n,
  input wire reset_pin_low_active,
  input wire tx_key,
  input wire lock_detect,
  input wire tx_enable,
  input wire batt_below_level,
  input wire batt_dead_raw,
  output wire [5:0] batt_level_code,
  output wire batt_hysteresis,
  output wire cpu_clk,
  output wire cpu_tick,
  output wire osc_enable,
  output wire cpu_run,
  output wire watchdog_run,
  output reg cpu_reboot
);
  localparam ST_RUN = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_WAKE = 2'h2;

  reg [7:0] dir_q;
  reg [5:0] out_q;
  reg [1:0] sel_q;
  reg test_q;
  reg boot_q;
  reg [5:0] btn_q;
  reg [5:0] btn_d;
  reg [5:0] level_q;
  reg [1:0] st_q;
  reg [7:0] wait_q;
  reg [5:0] pin_s1;
  reg [5:0] pin_s2;
  reg rpin_s1;
  reg rpin_s2;
  reg dead_s1;
  reg dead_s2;
  reg sclk_q;
  reg [4:0] ser_cnt_q;
  reg [15:0] ser_sh_q;
  reg [7:0] ser_out_q;
  reg ser_wr_q;
  reg [5:0] ser_addr_q;
  reg [7:0] ser_wdata_q;
  reg [5:0] drv_o;
  reg [5:0] drv_oe_n;

  wire bat_result;
  wire bat_valid;
  wire prog_mode;
  wire sclk_rise;
  wire sclk_fall;
  wire wr_en;
  wire [5:0] wr_addr;
  wire [7:0] wr_data;
  wire bat_restart;
  wire sleep_req;
  wire [5:0] btn_mode;
  wire [5:0] btn_low;
  wire wake_press;
  wire [1:0] div_sel;
  wire div_run;

  // Serial access only while test mode set and reset pin held low
  assign prog_mode = test_q & ~rpin_s2;
  assign sclk_rise = pin_s2[2] & ~sclk_q;
  assign sclk_fall = ~pin_s2[2] & sclk_q;

  // Serial write wins a same-cycle clash with the processor
  assign wr_en = ser_wr_q | cpu_io_wr;
  assign wr_addr = ser_wr_q ? ser_addr_q : cpu_io_addr;
  assign wr_data = ser_wr_q ? ser_wdata_q : cpu_io_wdata;
  assign bat_restart = wr_en && (wr_addr == `ADDR_BAT_CFG);
  assign sleep_req = wr_en && (wr_addr == `ADDR_SYS_CFG) &&
                     wr_data[`CFG_SLEEP_BIT];

  assign batt_level_code = level_q;
  assign batt_hysteresis = dir_q[`DIR_HYST_BIT];

  assign osc_enable = (st_q != ST_SLEEP);
  assign cpu_run = (st_q == ST_RUN);
  assign watchdog_run = (st_q == ST_RUN);
  assign div_sel = prog_mode ? `SEL_DIV16 : sel_q;
  assign div_run = (st_q == ST_RUN) | prog_mode;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_pin
      // Direction low with data high makes the pin a button
      assign btn_mode[gi] = ~dir_q[gi] & out_q[gi];
      assign btn_low[gi] = btn_mode[gi] & ~pin_s2[gi];
    end
  endgenerate

  assign wake_press = |btn_low;

  function [7:0] reg_read;
    input [5:0] a;
    input from_ser;
    begin
      case (a)
        `ADDR_PIN_DIR: reg_read = dir_q;
        `ADDR_PIN_OUT: reg_read = {2'h0, out_q};
        `ADDR_PIN_IN: reg_read = {2'h0, pin_s2};
        `ADDR_SYS_CFG: reg_read = {1'b0, sel_q, test_q,
                                   from_ser & dead_s2,
                                   bat_result,
                                   1'b0, boot_q};
        `ADDR_BTN_DET: reg_read = {2'h0, btn_q};
        `ADDR_BAT_CFG: reg_read = {bat_result, bat_valid, level_q};
        default: reg_read = 8'h00;
      endcase
    end
  endfunction

  // Pin mode per bit; test mode and serial port override direction
  always @*
  begin
    drv_o = out_q;
    drv_oe_n = ~dir_q[5:0];
    if (test_q)
    begin
      drv_o[5] = tx_key;
      drv_o[4] = lock_detect;
      drv_o[3] = tx_enable;
      drv_o[2] = 1'b0;
      drv_o[1] = ser_out_q[7];
      drv_o[0] = 1'b0;
      // Clock and data-in pins always float; data-out pin floats while reset pin is high
      drv_oe_n[2] = 1'b1;
      drv_oe_n[1] = ~prog_mode;
      drv_oe_n[0] = 1'b1;
    end
  end

  // Set wins over a same-cycle clear; only written zeros clear
  always @*
  begin
    btn_d = btn_q;
    if (wr_en && (wr_addr == `ADDR_BTN_DET))
    begin
      btn_d = btn_q & wr_data[5:0];
    end
    if (!dead_s2)
    begin
      btn_d = btn_d | btn_low;
    end
  end

  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_s1 <= `RST_SIX;
      pin_s2 <= `RST_SIX;
      rpin_s1 <= 1'b1;
      rpin_s2 <= 1'b1;
      dead_s1 <= 1'b0;
      dead_s2 <= 1'b0;
      sclk_q <= 1'b0;
      pin_o <= `RST_SIX;
      pin_oe_n <= 6'h3F;
    end
    else
    begin
      pin_s1 <= pin_i;
      pin_s2 <= pin_s1;
      rpin_s1 <= reset_pin_low_active;
      rpin_s2 <= rpin_s1;
      dead_s1 <= batt_dead_raw;
      dead_s2 <= dead_s1;
      sclk_q <= pin_s2[2];
      pin_o <= drv_o;
      pin_oe_n <= drv_oe_n;
    end
  end

  // Register file
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      dir_q <= `RST_BYTE;
      out_q <= `RST_SIX;
      sel_q <= `RST_TWO;
      test_q <= 1'b0;
      boot_q <= 1'b0;
      btn_q <= `RST_SIX;
      level_q <= `RST_SIX;
      cpu_io_rdata <= `RST_BYTE;
    end
    else
    begin
      btn_q <= btn_d;
      if (cpu_io_rd)
      begin
        cpu_io_rdata <= reg_read(cpu_io_addr, 1'b0);
      end
      if (wr_en)
      begin
        case (wr_addr)
          `ADDR_PIN_DIR: dir_q <= wr_data;
          `ADDR_PIN_OUT: out_q <= wr_data[5:0];
          `ADDR_SYS_CFG:
          begin
            sel_q <= wr_data[`CFG_SEL_HI:`CFG_SEL_LO];
            test_q <= wr_data[`CFG_TEST_BIT];
          end
          `ADDR_BAT_CFG: level_q <= wr_data[5:0];
          default: level_q <= level_q;
        endcase
      end
      // The reboot pulse clears the boot bit over any same-cycle write
      if (cpu_reboot)
      begin
        boot_q <= 1'b0;
      end
      else if (wr_en && (wr_addr == `ADDR_SYS_CFG))
      begin
        boot_q <= wr_data[`CFG_BOOT_BIT];
      end
    end
  end

  // Sleep and wake sequencing
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= ST_RUN;
      wait_q <= 8'h00;
      cpu_reboot <= 1'b0;
    end
    else
    begin
      cpu_reboot <= 1'b0;
      case (st_q)
        ST_RUN:
        begin
          if (sleep_req)
          begin
            st_q <= ST_SLEEP;
          end
        end
        ST_SLEEP:
        begin
          wait_q <= 8'h00;
          if (wake_press)
          begin
            st_q <= ST_WAKE;
          end
        end
        ST_WAKE:
        begin
          // Give the oscillator and dead-level sense time to settle
          wait_q <= wait_q + 8'h01;
          if (wait_q == `WAKE_SETTLE_CYCLES)
          begin
            if (dead_s2)
            begin
              st_q <= ST_SLEEP;
            end
            else
            begin
              st_q <= ST_RUN;
              cpu_reboot <= boot_q;
            end
          end
        end
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // Serial frame: write flag and address, then eight data bits
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ser_cnt_q <= 5'h00;
      ser_sh_q <= 16'h0000;
      ser_out_q <= `RST_BYTE;
      ser_wr_q <= 1'b0;
      ser_addr_q <= `RST_SIX;
      ser_wdata_q <= `RST_BYTE;
    end
    else
    begin
      ser_wr_q <= 1'b0;
      if (!prog_mode)
      begin
        ser_cnt_q <= 5'h00;
        ser_out_q <= `RST_BYTE;
      end
      else if (sclk_rise)
      begin
        ser_sh_q <= {ser_sh_q[14:0], pin_s2[0]};
        if (ser_cnt_q == `SER_HDR_BITS - 5'h01)
        begin
          ser_addr_q <= {ser_sh_q[4:0], pin_s2[0]};
          ser_out_q <= reg_read({ser_sh_q[4:0], pin_s2[0]}, 1'b1);
        end
        if (ser_cnt_q == `SER_FRAME_BITS - 5'h01)
        begin
          ser_cnt_q <= 5'h00;
          ser_wdata_q <= {ser_sh_q[6:0], pin_s2[0]};
          ser_wr_q <= ser_sh_q[`SER_WRITE_BIT + 7];
        end
        else
        begin
          ser_cnt_q <= ser_cnt_q + 5'h01;
        end
      end
      else if (sclk_fall && (ser_cnt_q > `SER_HDR_BITS))
      begin
        // Readback shifts out after the header, one bit per falling edge
        ser_out_q <= {ser_out_q[6:0], 1'b0};
      end
    end
  end

  cpu_clock_divider u_div
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .run(div_run),
    .sel(div_sel),
    .cpu_clk(cpu_clk),
    .cpu_tick(cpu_tick)
  );

  battery_sampler u_bat
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .restart(bat_restart),
    .below_level_raw(batt_below_level),
    .low_result(bat_result),
    .low_valid(bat_valid)
  );
endmodule

// ==== dv/pin_partner.sv ====
// Button and pull-up model standing at the six pins
`timescale 1ns/1ps
module pin_partner
(
  input wire [5:0] pin_o,
  input wire [5:0] pin_oe_n,
  input wire [5:0] press,
  output wire [5:0] pin_i
);
  // Released pins rest high on pull-ups; a held button pulls low
  assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & ~press);
endmodule

// ==== dv/io_wake_assertions.sv ====
// Port-level checker for the I/O wake and battery control block
`timescale 1ns/1ps
`include "io_wake_defines.vh"
module io_wake_checker
(
  input wire clk_sys,
  input wire rstn,
  input wire [5:0] cpu_io_addr,
  input wire [7:0] cpu_io_wdata,
  input wire cpu_io_wr,
  input wire cpu_io_rd,
  input wire [7:0] cpu_io_rdata,
  input wire [5:0] batt_level_code,
  input wire cpu_tick,
  input wire osc_enable,
  input wire cpu_run,
  input wire watchdog_run,
  input wire cpu_reboot
);
  reg [7:0] cnt_q;
  reg seen_q;
  reg gap_q;
  wire [5:0] wlevel = cpu_io_wdata[5:0];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // Periods that touched a stop are partial by nature, so skip them
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 8'h00;
      seen_q <= 1'b0;
      gap_q <= 1'b0;
    end
    else if (cpu_tick)
    begin
      cnt_q <= 8'h00;
      seen_q <= 1'b1;
      gap_q <= !cpu_run;
    end
    else
    begin
      if (cnt_q != 8'hFF)
        cnt_q <= cnt_q + 8'h01;
      if (!cpu_run)
        gap_q <= 1'b1;
    end
  end
  sequence s_sleep_wr;
    cpu_io_wr && cpu_io_addr == `ADDR_SYS_CFG &&
      cpu_io_wdata[`CFG_SLEEP_BIT] && cpu_run;
  endsequence
  sequence s_asleep;
    !osc_enable && !cpu_run && !watchdog_run;
  endsequence
  property p_sleep;
    s_sleep_wr |-> ##[1:3] s_asleep;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep write did not halt the part");
  property p_halt;
    !osc_enable |-> !cpu_run && !watchdog_run;
  endproperty
  a_halt: assert property (p_halt)
    else $error("processor or watchdog ran without oscillator");
  property p_wake;
    $rose(osc_enable) |-> !cpu_run [*8];
  endproperty
  a_wake: assert property (p_wake)
    else $error("processor resumed before battery check");
  property p_reboot_run;
    cpu_reboot |-> ##[0:1] cpu_run;
  endproperty
  a_reboot_run: assert property (p_reboot_run)
    else $error("reboot without resuming");
  property p_reboot_pulse;
    cpu_reboot |=> !cpu_reboot;
  endproperty
  a_reboot_pulse: assert property (p_reboot_pulse)
    else $error("reboot pulse too long");
  property p_upper;
    cpu_io_rd && (cpu_io_addr == `ADDR_PIN_OUT ||
      cpu_io_addr == `ADDR_PIN_IN || cpu_io_addr == `ADDR_BTN_DET)
      |=> cpu_io_rdata[7:6] == 2'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("reserved bits read nonzero");
  property p_dead;
    cpu_io_rd && cpu_io_addr == `ADDR_SYS_CFG
      |=> !cpu_io_rdata[`CFG_DEAD_BIT];
  endproperty
  a_dead: assert property (p_dead)
    else $error("dead flag visible to processor");
  property p_level;
    cpu_io_wr && cpu_io_addr == `ADDR_BAT_CFG
      |=> batt_level_code == $past(wlevel);
  endproperty
  a_level: assert property (p_level)
    else $error("level code not forwarded");
  property p_period;
    cpu_tick && seen_q && !gap_q
      |-> cnt_q inside {8'h0F, 8'h1F, 8'h3F, 8'h7F};
  endproperty
  a_period: assert property (p_period)
    else $error("processor clock period wrong or shortened");
endmodule
bind io_wake_battery_control io_wake_checker i_io_wake_checker
(
  .clk_sys(clk_sys), .rstn(rstn), .cpu_io_addr(cpu_io_addr),
  .cpu_io_wdata(cpu_io_wdata), .cpu_io_wr(cpu_io_wr),
  .cpu_io_rd(cpu_io_rd), .cpu_io_rdata(cpu_io_rdata),
  .batt_level_code(batt_level_code), .cpu_tick(cpu_tick),
  .osc_enable(osc_enable), .cpu_run(cpu_run),
  .watchdog_run(watchdog_run), .cpu_reboot(cpu_reboot)
);

// ==== dv/test_io_wake_battery_control.sv ====
// Self-checking bench for the I/O wake and battery control block
`timescale 1ns/1ps
`include "io_wake_defines.vh"
module test_io_wake_battery_control;
  reg clk_sys, rstn, cpu_io_wr, cpu_io_rd, rpin;
  reg [5:0] cpu_io_addr, press;
  reg [7:0] cpu_io_wdata, d, o, r;
  reg tx_key, lock_detect, tx_enable, batt_below_level, batt_dead_raw;
  reg [31:0] rnd;
  wire [7:0] cpu_io_rdata;
  wire [5:0] pin_i, pin_o, pin_oe_n, lvl;
  wire hyst, cpu_clk, cpu_tick, osc_enable, cpu_run, wd_run, reboot;
  integer seed, fail_count, tests_run, i, n;
  io_wake_battery_control i_io_wake_battery_control
  (
    .clk_sys(clk_sys), .rstn(rstn), .cpu_io_addr(cpu_io_addr),
    .cpu_io_wdata(cpu_io_wdata), .cpu_io_wr(cpu_io_wr),
    .cpu_io_rd(cpu_io_rd), .cpu_io_rdata(cpu_io_rdata), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .reset_pin_low_active(rpin),
    .tx_key(tx_key), .lock_detect(lock_detect), .tx_enable(tx_enable),
    .batt_below_level(batt_below_level), .batt_dead_raw(batt_dead_raw),
    .batt_level_code(lvl), .batt_hysteresis(hyst), .cpu_clk(cpu_clk),
    .cpu_tick(cpu_tick), .osc_enable(osc_enable), .cpu_run(cpu_run),
    .watchdog_run(wd_run), .cpu_reboot(reboot)
  );
  pin_partner i_pin_partner
  (
    .pin_o(pin_o), .pin_oe_n(pin_oe_n), .press(press), .pin_i(pin_i)
  );
  function [7:0] exp_pins(input [7:0] dv, input [7:0] ov);
    exp_pins = {2'h0, (ov[5:0] & dv[5:0]) | (~dv[5:0] & ~press)};
  endfunction
  function [7:0] exp_gap(input [1:0] s);
    exp_gap = 8'h10 << (2'h3 - s);
  endfunction
  task chk(input [7:0] e, input [7:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  end
  endtask
  task cyc(input integer k);
    repeat (k) @(negedge clk_sys);
  endtask
  task wr(input [5:0] a, input [7:0] v);
  begin
    @(negedge clk_sys);
    cpu_io_addr = a;
    cpu_io_wdata = v;
    cpu_io_wr = 1'b1;
    @(negedge clk_sys);
    cpu_io_wr = 1'b0;
  end
  endtask
  task rdchk(input [5:0] a, input [7:0] e);
  begin
    @(negedge clk_sys);
    cpu_io_addr = a;
    cpu_io_rd = 1'b1;
    @(negedge clk_sys);
    cpu_io_rd = 1'b0;
    r = cpu_io_rdata;
    chk(e, r);
  end
  endtask
  // Bounded wait on the reboot pulse (w=1) or on the run flag (w=0)
  task wait_on(input integer w);
  begin
    n = 0;
    while ((w ? reboot : cpu_run) !== 1'b1 && n < 300)
    begin
      @(negedge clk_sys);
      n = n + 1;
    end
  end
  endtask
  // Sixteen-bit serial frame, MSB first; a press pulls the pin low
  task ser_frame(input [15:0] f);
  begin
    for (n = 15; n >= 0; n = n - 1)
    begin
      press[2] = 1'b1;
      press[0] = ~f[n];
      cyc(4);
      press[2] = 1'b0;
      cyc(4);
    end
    press = 6'h00;
  end
  endtask
  // The first tick after a select write may still close an old period
  task tick_gap;
  begin
    wait_tick();
    cyc(1);
    wait_tick();
    n = 1;
    @(negedge clk_sys);
    while (cpu_tick !== 1'b1 && n < 300)
    begin
      @(negedge clk_sys);
      n = n + 1;
    end
  end
  endtask
  task wait_tick;
    repeat (300) if (cpu_tick !== 1'b1) @(negedge clk_sys);
  endtask
  task complete_run;
  begin
    $display("Counts: tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Whole run is near 7500 cycles; 20000 cycles means a hang
  initial
  begin
    #100000;
    fail_count = fail_count + 1;
    complete_run();
  end
  initial
  begin
    seed = 89985;
    fail_count = 0;
    tests_run = 0;
    {rstn, cpu_io_wr, cpu_io_rd, cpu_io_addr, cpu_io_wdata} = 0;
    {tx_key, lock_detect, tx_enable, batt_below_level} = 0;
    batt_dead_raw = 1'b0;
    rpin = 1'b1;
    press = 6'h00;
    cyc(10);
    rstn = 1'b1;
    for (i = 0; i < 6; i = i + 1)
      rdchk(6'h30 + i, i == 2 ? exp_pins(0, 0) : 8'h00);
    wr(6'h3F, 8'hFF);
    rdchk(6'h3F, 8'h00);
    for (i = 0; i < 6; i = i + 1)
    begin
      rnd = $random(seed);
      d = {2'h0, rnd[5:0]};
      o = rnd[15:8];
      wr(`ADDR_PIN_DIR, d);
      wr(`ADDR_PIN_OUT, o);
      wr(`ADDR_PIN_IN, rnd[23:16]);
      cyc(4);
      chk({2'h0, ~pin_oe_n}, d);
      chk({2'h0, pin_o & d[5:0]}, {2'h0, o[5:0] & d[5:0]});
      rdchk(`ADDR_PIN_OUT, {2'h0, o[5:0]});
      rdchk(`ADDR_PIN_IN, exp_pins(d, o));
    end
    wr(`ADDR_PIN_DIR, 8'h00);
    wr(`ADDR_PIN_OUT, 8'h3F);
    wr(`ADDR_BTN_DET, 8'h00);
    rnd = $random(seed);
    press = rnd[5:0] | 6'h01;
    cyc(5);
    rdchk(`ADDR_BTN_DET, {2'h0, press});
    d = {2'h0, press};
    press = 6'h00;
    wr(`ADDR_BTN_DET, 8'hFF);
    rdchk(`ADDR_BTN_DET, d);
    wr(`ADDR_BTN_DET, ~d);
    rdchk(`ADDR_BTN_DET, 8'h00);
    batt_dead_raw = 1'b1;
    press = 6'h3F;
    cyc(5);
    rdchk(`ADDR_BTN_DET, 8'h00);
    press = 6'h00;
    batt_dead_raw = 1'b0;
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`ADDR_SYS_CFG, i << 5);
      tick_gap();
      chk(n, exp_gap(i));
      rdchk(`ADDR_SYS_CFG, i << 5);
    end
    rnd = $random(seed);
    {tx_key, lock_detect, tx_enable} = rnd[2:0];
    wr(`ADDR_PIN_DIR, 8'h3F);
    wr(`ADDR_SYS_CFG, 8'h70);
    cyc(4);
    chk({5'h0, pin_o[5:3]}, {5'h0, rnd[2:0]});
    chk({2'h0, pin_oe_n}, 8'h07);
    wr(`ADDR_SYS_CFG, 8'h60);
    wr(`ADDR_PIN_DIR, 8'h00);
    wr(`ADDR_PIN_OUT, 8'h01);
    wr(`ADDR_SYS_CFG, 8'h63);
    cyc(3);
    chk({5'h0, osc_enable, cpu_run, wd_run}, 8'h00);
    press = 6'h01;
    wait_on(1);
    chk({7'h0, reboot}, 8'h01);
    press = 6'h00;
    cyc(2);
    chk({6'h0, cpu_run, wd_run}, 8'h03);
    rdchk(`ADDR_SYS_CFG, 8'h60);
    batt_dead_raw = 1'b1;
    wr(`ADDR_SYS_CFG, 8'h62);
    cyc(3);
    press = 6'h01;
    cyc(20);
    press = 6'h00;
    cyc(80);
    chk({7'h0, osc_enable}, 8'h00);
    batt_dead_raw = 1'b0;
    press = 6'h01;
    wait_on(0);
    chk({7'h0, cpu_run}, 8'h01);
    press = 6'h00;
    o = 8'h00;
    for (i = 0; i < 2; i = i + 1)
    begin
      rnd = $random(seed);
      batt_below_level = rnd[6];
      wr(`ADDR_BAT_CFG, {2'h0, rnd[5:0]});
      rdchk(`ADDR_BAT_CFG, o | rnd[5:0]);
      chk({7'h0, r[6]}, 8'h00);
      chk({2'h0, lvl}, {2'h0, rnd[5:0]});
      cyc(3100);
      rdchk(`ADDR_BAT_CFG, {rnd[6], 1'b1, rnd[5:0]});
      rdchk(`ADDR_SYS_CFG, {3'h3, 2'h0, rnd[6], 2'h0});
      o = {rnd[6], 7'h00};
    end
    rpin = 1'b0;
    wr(`ADDR_SYS_CFG, 8'h70);
    ser_frame({2'h2, `ADDR_PIN_OUT, 8'h2A});
    cyc(3);
    rdchk(`ADDR_PIN_OUT, 8'h2A);
    rpin = 1'b1;
    wr(`ADDR_SYS_CFG, 8'h60);
    complete_run();
  end
endmodule
